// ### sss_defs.svh
// Register offsets, reset values and bit positions of the status summary block.
// Assumes a 32-bit AXI4-Lite slave with word-aligned byte addresses.
`ifndef SSS_DEFS_SVH
`define SSS_DEFS_SVH
`define SSS_OFF_STB       8'h00
`define SSS_OFF_SRE       8'h04
`define SSS_OFF_CMD       8'h08
`define SSS_OFF_QSTAT     8'h0c
`define SSS_OFF_IRQ_STAT  8'h10
`define SSS_OFF_IRQ_MASK  8'h14
`define SSS_OFF_SET_BASE  8'h20
`define SSS_OFF_COND      2'h0
`define SSS_OFF_EVENT     2'h1
`define SSS_OFF_ENABLE    2'h2
`define SSS_RST_REG       16'h0000
`define SSS_RST_BYTE      8'h00
`define SSS_STB_MEAS      0
`define SSS_STB_EAV       2
`define SSS_STB_QUES      3
`define SSS_STB_MAV       4
`define SSS_STB_ESB       5
`define SSS_STB_MSS       6
`define SSS_STB_OPER      7
`define SSS_CMD_CLS       0
`define SSS_CMD_PRESET    1
`define SSS_CMD_QCLR      2
`define SSS_CMD_SYSCLR    3
`define SSS_CMD_SYSPRE    4
`define SSS_CMD_RST       5
`define SSS_CMD_OQ_POP    6
`define SSS_CMD_EQ_POP    7
`define SSS_SET_STD       2'd0
`define SSS_SET_OPER      2'd1
`define SSS_SET_MEAS      2'd2
`define SSS_SET_QUES      2'd3
`define SSS_RESP_OKAY     2'b00
`define SSS_RESP_SLVERR   2'b10
`endif

// ### sss_pkg.sv
// Types shared by the status summary block.
// Assumes sss_defs.svh is compiled alongside.
package sss_pkg;
    typedef struct packed {
        logic [3:0][15:0] cond;
        logic [3:0][15:0] event_set;
    } sss_events_t;
    typedef enum logic [2:0] {
        SSS_IDLE = 3'b001,
        SSS_WRSP = 3'b010,
        SSS_RRSP = 3'b100
    } sss_state_t;
endpackage : sss_pkg

// ### sss_status_summary.sv
// Status summary structure: four register sets, two queue counters, status
// byte and service request, reached over AXI4-Lite.
// Assumes event and condition inputs are synchronous to aclk; queue pushes
// are one-cycle pulses from the same domain.
//
// Behaviour
// - Status byte gathers four set summaries and two queue summaries.
// - Master summary bit set when any summary bit and its enable are set.
// - Condition registers are read-only and follow live conditions.
// - An event latches its event bit to one until that register resets.
// - Set summary is one when any event bit and its enable are set.
// - Each queue raises its summary bit while it holds any entry.
// - Query responses enter the output queue, errors the error queue.
// - Reset clears every register and empties both queues.
// - Writing zero to an enable register clears all its bits.
// - System preset and reset commands leave registers and queues alone.
// - Clear-status resets all four event registers and the error queue.
// - Status preset clears three enable registers, not the error queue.
// - Standard enable register changes only through its own write.
// - Queue clear or system clear empties the error queue.
// - Only enable, mask and command registers accept writes; others are read-only.
// - Enable value is binary weighted, bit n worth two to the n.
// - Register reads return contents in plain binary weighting.
`include "sss_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module sss_status_summary
    import sss_pkg::*;
#(
    parameter int QDEPTH = 16
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire sss_events_t events,
    input  wire logic        out_queue_push,
    input  wire logic        err_queue_push,
    output var  logic        mss,
    output var  logic        irq
);

    localparam int QW = $clog2(QDEPTH + 1);

    ////////////////////////////////////////////////////////////////////////////
    // Address decode helpers.

    function automatic logic is_set_reg(input logic [7:0] a,
                                        input logic [1:0] kind);
        logic [7:0] rel;
        rel        = a - `SSS_OFF_SET_BASE;
        is_set_reg = (a >= `SSS_OFF_SET_BASE) && (rel[7:6] == 2'b00)
                     && (rel[3:2] == kind) && (rel[1:0] == 2'b00);
    endfunction : is_set_reg

    function automatic logic [1:0] set_of(input logic [7:0] a);
        logic [7:0] rel;
        rel    = a - `SSS_OFF_SET_BASE;
        set_of = rel[5:4];
    endfunction : set_of

    ////////////////////////////////////////////////////////////////////////////
    // Bus state.

    sss_state_t  state;
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        do_write;
    logic        do_read;
    logic [7:0]  rd_addr;

    logic [3:0][15:0] cond_q;
    logic [3:0][15:0] event_q;
    logic [3:0][15:0] enable_q;
    logic [7:0]       sre;
    logic [7:0]       cmd_pulse;
    logic [QW-1:0]    oq_count;
    logic [QW-1:0]    eq_count;
    logic [1:0]       irq_stat;
    logic [1:0]       irq_mask;
    logic [3:0]       set_summary;
    logic [7:0]       stb;
    logic [31:0]      next_rdata;
    logic             rd_ok;
    logic             wr_ok;
    logic             rd_event;
    logic             rd_irq;

    // A read taken now goes first.
    assign do_write = (state == SSS_IDLE) && aw_held && w_held
                      && !(s_axi_arvalid && s_axi_arready);
    assign do_read  = (state == SSS_IDLE) && !do_write && s_axi_arvalid
                      && s_axi_arready;
    assign rd_addr  = s_axi_araddr;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_awready <= (state == SSS_IDLE) && !aw_held
                             && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= (state == SSS_IDLE) && !w_held
                             && !(s_axi_wvalid && s_axi_wready);
            s_axi_arready <= (state == SSS_IDLE) && !s_axi_arready
                             && !(aw_held && w_held);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state        <= SSS_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `SSS_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= `SSS_RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
        end else begin
            case (state)
                SSS_IDLE: begin
                    if (do_write) begin
                        state        <= SSS_WRSP;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp  <= wr_ok ? `SSS_RESP_OKAY
                                              : `SSS_RESP_SLVERR;
                    end else if (do_read) begin
                        state        <= SSS_RRSP;
                        s_axi_rvalid <= 1'b1;
                        s_axi_rdata  <= next_rdata;
                        s_axi_rresp  <= rd_ok ? `SSS_RESP_OKAY
                                              : `SSS_RESP_SLVERR;
                    end
                end
                SSS_WRSP: begin
                    if (s_axi_bready) begin
                        state        <= SSS_IDLE;
                        s_axi_bvalid <= 1'b0;
                    end
                end
                SSS_RRSP: begin
                    if (s_axi_rready) begin
                        state        <= SSS_IDLE;
                        s_axi_rvalid <= 1'b0;
                    end
                end
                default: begin
                    state        <= SSS_IDLE;
                    s_axi_bvalid <= 1'b0;
                    s_axi_rvalid <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write decode. Only enable, mask and command words are writable.

    always_comb begin
        wr_ok = (aw_addr == `SSS_OFF_SRE) || (aw_addr == `SSS_OFF_CMD)
                || (aw_addr == `SSS_OFF_IRQ_MASK)
                || is_set_reg(aw_addr, `SSS_OFF_ENABLE);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_pulse <= `SSS_RST_BYTE;
        end else if (do_write && aw_addr == `SSS_OFF_CMD && w_strb[0]) begin
            cmd_pulse <= w_data[7:0];
        end else begin
            cmd_pulse <= `SSS_RST_BYTE;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sre <= `SSS_RST_BYTE;
        end else if (do_write && aw_addr == `SSS_OFF_SRE && w_strb[0]) begin
            sre <= w_data[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register sets. Commands land one cycle after the write completes.

    assign rd_event = do_read && is_set_reg(rd_addr, `SSS_OFF_EVENT);

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_set
            logic wr_en;
            logic rd_clr;
            assign wr_en  = do_write && is_set_reg(aw_addr, `SSS_OFF_ENABLE)
                            && set_of(aw_addr) == 2'(g);
            assign rd_clr = rd_event && set_of(rd_addr) == 2'(g);

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    cond_q[g] <= `SSS_RST_REG;
                end else begin
                    cond_q[g] <= events.cond[g];
                end
            end

            // Read clears, but an event in that cycle still lands.
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    event_q[g] <= `SSS_RST_REG;
                end else if (rd_clr || cmd_pulse[`SSS_CMD_CLS]) begin
                    event_q[g] <= events.event_set[g];
                end else begin
                    event_q[g] <= event_q[g] | events.event_set[g];
                end
            end

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    enable_q[g] <= `SSS_RST_REG;
                end else if (wr_en) begin
                    if (w_strb[0]) begin
                        enable_q[g][7:0] <= w_data[7:0];
                    end
                    if (w_strb[1]) begin
                        enable_q[g][15:8] <= w_data[15:8];
                    end
                end else if (cmd_pulse[`SSS_CMD_PRESET]
                             && 2'(g) != `SSS_SET_STD) begin
                    enable_q[g] <= `SSS_RST_REG;
                end
            end

            assign set_summary[g] = |(event_q[g] & enable_q[g]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Queue occupancy. The message payloads live elsewhere; only counts here.
    // System preset and reset commands are accepted but touch nothing.

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oq_count <= '0;
        end else if (out_queue_push && oq_count != QW'(QDEPTH)) begin
            if (!(cmd_pulse[`SSS_CMD_OQ_POP] && oq_count != '0)) begin
                oq_count <= oq_count + 1'b1;
            end
        end else if (cmd_pulse[`SSS_CMD_OQ_POP] && oq_count != '0) begin
            oq_count <= oq_count - 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eq_count <= '0;
        end else if (cmd_pulse[`SSS_CMD_CLS] || cmd_pulse[`SSS_CMD_QCLR]
                     || cmd_pulse[`SSS_CMD_SYSCLR]) begin
            eq_count <= QW'(err_queue_push);
        end else if (err_queue_push && eq_count != QW'(QDEPTH)) begin
            if (!(cmd_pulse[`SSS_CMD_EQ_POP] && eq_count != '0)) begin
                eq_count <= eq_count + 1'b1;
            end
        end else if (cmd_pulse[`SSS_CMD_EQ_POP] && eq_count != '0) begin
            eq_count <= eq_count - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status byte and service request.

    always_comb begin
        stb = `SSS_RST_BYTE;
        stb[`SSS_STB_MEAS] = set_summary[`SSS_SET_MEAS];
        stb[`SSS_STB_EAV]  = eq_count != '0;
        stb[`SSS_STB_QUES] = set_summary[`SSS_SET_QUES];
        stb[`SSS_STB_MAV]  = oq_count != '0;
        stb[`SSS_STB_ESB]  = set_summary[`SSS_SET_STD];
        stb[`SSS_STB_OPER] = set_summary[`SSS_SET_OPER];
        stb[`SSS_STB_MSS]  = |(stb & sre);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mss <= 1'b0;
        end else begin
            mss <= stb[`SSS_STB_MSS];
        end
    end

    // Interrupt bit 0 latches service request, bit 1 an error push.
    assign rd_irq = do_read && rd_addr == `SSS_OFF_IRQ_STAT;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat <= 2'h0;
            irq_mask <= 2'h0;
            irq      <= 1'b0;
        end else begin
            irq_stat <= (rd_irq ? 2'h0 : irq_stat)
                        | {err_queue_push, stb[`SSS_STB_MSS]};
            if (do_write && aw_addr == `SSS_OFF_IRQ_MASK && w_strb[0]) begin
                irq_mask <= w_data[1:0];
            end
            irq <= |(irq_stat & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux, zero-extended binary contents.

    always_comb begin
        next_rdata = 32'h0000_0000;
        rd_ok      = 1'b1;
        if (rd_addr == `SSS_OFF_STB) begin
            next_rdata[7:0] = stb;
        end else if (rd_addr == `SSS_OFF_SRE) begin
            next_rdata[7:0] = sre;
        end else if (rd_addr == `SSS_OFF_QSTAT) begin
            next_rdata[15:8] = 8'(eq_count);
            next_rdata[7:0]  = 8'(oq_count);
        end else if (rd_addr == `SSS_OFF_IRQ_STAT) begin
            next_rdata[1:0] = irq_stat;
        end else if (rd_addr == `SSS_OFF_IRQ_MASK) begin
            next_rdata[1:0] = irq_mask;
        end else if (is_set_reg(rd_addr, `SSS_OFF_COND)) begin
            next_rdata[15:0] = cond_q[set_of(rd_addr)];
        end else if (is_set_reg(rd_addr, `SSS_OFF_EVENT)) begin
            next_rdata[15:0] = event_q[set_of(rd_addr)];
        end else if (is_set_reg(rd_addr, `SSS_OFF_ENABLE)) begin
            next_rdata[15:0] = enable_q[set_of(rd_addr)];
        end else begin
            rd_ok = 1'b0;
        end
    end

endmodule : sss_status_summary
`default_nettype wire

// ### sss_status_summary_asserts.sv
// Port-level assertions for the status summary block.
// Assumes one aclk domain; the bind sits at the foot of this file.
`include "sss_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module sss_status_summary_asserts
    import sss_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire sss_events_t events,
    input wire logic        out_queue_push,
    input wire logic        err_queue_push,
    input wire logic        mss,
    input wire logic        irq
);
    logic [7:0]       wa;
    logic [7:0]       ra;
    logic [31:0]      wd;
    logic [7:0]       sre;
    logic             pend;
    logic [3:0][15:0] cd1;
    logic [3:0][15:0] cd2;
    logic             sre_zero;
    // A write in flight to the enable counts as non-zero, so the shadow
    // copy may lag the block without giving false failures.
    assign sre_zero = sre == 8'h00 && !pend;
    always_ff @(posedge aclk) begin
        cd1 <= events.cond;
        cd2 <= cd1;
        if (!aresetn) begin
            wa   <= 8'h00;
            ra   <= 8'h00;
            wd   <= 32'h0;
            sre  <= 8'h00;
            pend <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wa   <= s_axi_awaddr;
                pend <= s_axi_awaddr == `SSS_OFF_SRE;
            end
            if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata;
            if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
            if (s_axi_bvalid && s_axi_bready) begin
                pend <= 1'b0;
                if (wa == `SSS_OFF_SRE && s_axi_bresp == `SSS_RESP_OKAY)
                    sre <= wd[7:0];
            end
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_rst;
        disable iff (1'b0)
        !aresetn |=> !mss && !irq && !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    a_rst: assert property (p_rst)
        else $error("outputs not cleared by reset");
    property p_ro;
        s_axi_bvalid && (wa == `SSS_OFF_STB || wa == `SSS_OFF_QSTAT)
            |-> s_axi_bresp == `SSS_RESP_SLVERR;
    endproperty
    a_ro: assert property (p_ro)
        else $error("read-only write accepted");
    property p_ro_set;
        s_axi_bvalid && wa inside {[8'h20:8'h5f]} && wa[3:2] != 2'b10
            |-> s_axi_bresp == `SSS_RESP_SLVERR;
    endproperty
    a_ro_set: assert property (p_ro_set)
        else $error("set register write accepted");
    property p_en;
        s_axi_bvalid && wa inside {[8'h20:8'h5f]} && wa[3:0] == 4'h8
            |-> s_axi_bresp == `SSS_RESP_OKAY;
    endproperty
    a_en: assert property (p_en)
        else $error("enable write refused");
    property p_cond;
        $rose(s_axi_rvalid) && ra inside {8'h20, 8'h30, 8'h40, 8'h50}
            |-> s_axi_rdata == {16'h0, cd2[ra[5:4] ^ 2'b10]};
    endproperty
    a_cond: assert property (p_cond)
        else $error("condition read not live");
    property p_mss0;
        sre_zero [*3] |-> !mss;
    endproperty
    a_mss0: assert property (p_mss0)
        else $error("mss set with no enable");
    property p_mav;
        sre[`SSS_STB_MAV] && !pend && out_queue_push && !s_axi_bvalid
            |-> ##[1:3] mss;
    endproperty
    a_mav: assert property (p_mav)
        else $error("output queue summary missing");
    property p_eav;
        sre[`SSS_STB_EAV] && !pend && err_queue_push && !s_axi_bvalid
            |-> ##[1:3] mss;
    endproperty
    a_eav: assert property (p_eav)
        else $error("error queue summary missing");
    c_mss: cover property ($rose(mss));
    c_irq: cover property ($rose(irq));
    c_err: cover property (s_axi_bvalid && s_axi_bresp == `SSS_RESP_SLVERR);
endmodule : sss_status_summary_asserts
bind sss_status_summary sss_status_summary_asserts sss_chk_i (.*);
`default_nettype wire

// ### tb.sv
// Self-checking bench for the status summary block.
// Assumes the checker file is compiled before this one.
`include "sss_defs.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        comparisons++; \
        if ((g) !== (e)) begin \
            n_errors++; \
            $display("wrong value %s expected %h seen %h", nm, e, g); \
        end \
    end
module tb
    import sss_pkg::*;
;
    localparam logic [1:0] OK = `SSS_RESP_OKAY;
    localparam logic [1:0] ER = `SSS_RESP_SLVERR;
    localparam int SB [4] = '{`SSS_STB_ESB, `SSS_STB_OPER,
                              `SSS_STB_MEAS, `SSS_STB_QUES};
    localparam logic [7:0] BAD [5] = '{8'h00, 8'h0c, 8'h20, 8'h44, 8'hf0};
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready = 1'b0;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready = 1'b0;
    sss_events_t events = '0;
    logic        out_queue_push = 1'b0;
    logic        err_queue_push = 1'b0;
    logic        mss;
    logic        irq;
    int          n_errors = 0;
    int          comparisons = 0;
    logic [33:0] expq [$];
    logic [33:0] m;
    logic [15:0] en [4];
    logic [15:0] ev [4];
    logic [7:0]  sre;
    logic [7:0]  oq;
    logic [7:0]  eq;
    always #12.5 aclk = ~aclk;
    sss_status_summary sss_status_summary_i (.*);
    ////////////////////////////////////////
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready) begin
            m = expq.pop_front();
            `CHK("bresp", m[33:32], s_axi_bresp)
        end
        if (s_axi_rvalid && s_axi_rready) begin
            m = expq.pop_front();
            `CHK("rresp", m[33:32], s_axi_rresp)
            `CHK("rdata", m[31:0], s_axi_rdata)
        end
    end
    task automatic stop_test();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        expq.push_back({er, w ? 32'h0 : d});
        if (w) begin
            s_axi_awaddr  <= a;
            s_axi_wdata   <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid  <= 1'b1;
            s_axi_bready  <= 1'b1;
        end else begin
            s_axi_araddr  <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready  <= 1'b1;
        end
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bready && s_axi_bvalid) s_axi_bready <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rready && s_axi_rvalid) s_axi_rready <= 1'b0;
        end while ((s_axi_awvalid || s_axi_wvalid || s_axi_bready ||
                    s_axi_arvalid || s_axi_rready) && n < 200);
        if (n >= 200) begin
            n_errors++;
            stop_test();
        end
    endtask : xfer
    function automatic logic [7:0] sa(input int s, input int o);
        return 8'(`SSS_OFF_SET_BASE + s * 16 + o * 4);
    endfunction : sa
    function automatic logic [7:0] stb_m();
        logic [7:0] b;
        b = 8'h00;
        for (int s = 0; s < 4; s++) b[SB[s]] = |(ev[s] & en[s]);
        b[`SSS_STB_EAV] = eq != 8'h00;
        b[`SSS_STB_MAV] = oq != 8'h00;
        b[`SSS_STB_MSS] = |(b & sre & 8'hbf);
        return b;
    endfunction : stb_m
    task automatic clr_model();
        sre = 8'h00;
        oq = 8'h00;
        eq = 8'h00;
        en = '{default: 16'h0};
        ev = '{default: 16'h0};
    endtask : clr_model
    task automatic chk_all();
        xfer(1'b0, `SSS_OFF_STB, {24'h0, stb_m()}, OK);
        xfer(1'b0, `SSS_OFF_SRE, {24'h0, sre}, OK);
        xfer(1'b0, `SSS_OFF_QSTAT, {16'h0, eq, oq}, OK);
        for (int s = 0; s < 4; s++) begin
            xfer(1'b0, sa(s, `SSS_OFF_ENABLE), {16'h0, en[s]}, OK);
            xfer(1'b0, sa(s, `SSS_OFF_EVENT), {16'h0, ev[s]}, OK);
            ev[s] = 16'h0;
        end
    endtask : chk_all
    task automatic hit(input logic [3:0] sets, input logic o, input logic e);
        logic [15:0] p;
        @(posedge aclk);
        for (int s = 0; s < 4; s++) begin
            p = sets[s] ? 16'($urandom) : 16'h0;
            ev[s] = ev[s] | p;
            events.event_set[s] <= p;
        end
        out_queue_push <= o;
        err_queue_push <= e;
        oq = oq + 8'(o);
        eq = eq + 8'(e);
        @(posedge aclk);
        events.event_set <= '0;
        out_queue_push <= 1'b0;
        err_queue_push <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask : hit
    task automatic cmd(input int b);
        xfer(1'b1, `SSS_OFF_CMD, 32'h1 << b, OK);
        case (b)
            `SSS_CMD_CLS: begin
                ev = '{default: 16'h0};
                eq = 8'h00;
            end
            `SSS_CMD_PRESET: for (int s = 1; s < 4; s++) en[s] = 16'h0;
            `SSS_CMD_QCLR, `SSS_CMD_SYSCLR: eq = 8'h00;
            `SSS_CMD_OQ_POP: oq = oq - 8'h01;
            `SSS_CMD_EQ_POP: eq = eq - 8'h01;
            default: ;
        endcase
    endtask : cmd
    ////////////////////////////////////////
    initial begin
        void'($urandom(32'h2c6f));
        clr_model();
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk_all();
        xfer(1'b0, `SSS_OFF_IRQ_STAT, 32'h0, OK);
        foreach (BAD[i]) xfer(1'b1, BAD[i], 32'hffff, ER);
        xfer(1'b0, 8'hf0, 32'h0, ER);
        for (int s = 0; s < 4; s++) begin
            en[s] = 16'($urandom);
            xfer(1'b1, sa(s, `SSS_OFF_ENABLE), {16'h0, en[s]}, OK);
        end
        sre = 8'hbd;
        xfer(1'b1, `SSS_OFF_SRE, 32'hbd, OK);
        repeat (2) begin
            for (int s = 0; s < 4; s++) events.cond[s] <= 16'($urandom);
            repeat (3) @(posedge aclk);
            for (int s = 0; s < 4; s++)
                xfer(1'b0, sa(s, 0), {16'h0, events.cond[s]}, OK);
        end
        hit(4'hf, 1'b1, 1'b1);
        hit(4'h0, 1'b1, 1'b0);
        `CHK("mss", |(stb_m() & 8'h40), mss)
        chk_all();
        chk_all();
        cmd(`SSS_CMD_SYSPRE);
        cmd(`SSS_CMD_RST);
        chk_all();
        hit(4'hf, 1'b0, 1'b1);
        cmd(`SSS_CMD_PRESET);
        chk_all();
        hit(4'hf, 1'b0, 1'b0);
        cmd(`SSS_CMD_CLS);
        chk_all();
        hit(4'h0, 1'b0, 1'b1);
        cmd(`SSS_CMD_QCLR);
        hit(4'h0, 1'b0, 1'b1);
        cmd(`SSS_CMD_SYSCLR);
        hit(4'h0, 1'b0, 1'b1);
        cmd(`SSS_CMD_EQ_POP);
        cmd(`SSS_CMD_OQ_POP);
        cmd(`SSS_CMD_OQ_POP);
        chk_all();
        en = '{default: 16'h0};
        sre = 8'h00;
        for (int s = 0; s < 4; s++)
            xfer(1'b1, sa(s, `SSS_OFF_ENABLE), 32'h0, OK);
        xfer(1'b1, `SSS_OFF_SRE, 32'h0, OK);
        hit(4'hf, 1'b1, 1'b1);
        `CHK("mss", |(stb_m() & 8'h40), mss)
        chk_all();
        // A second reset in mid-run, then the interrupt path from scratch.
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        clr_model();
        @(posedge aclk);
        xfer(1'b1, `SSS_OFF_IRQ_MASK, 32'h2, OK);
        hit(4'h0, 1'b0, 1'b1);
        `CHK("irq", 1'b1, irq)
        xfer(1'b0, `SSS_OFF_IRQ_STAT, 32'h2, OK);
        repeat (2) @(posedge aclk);
        `CHK("irq", 1'b0, irq)
        xfer(1'b1, `SSS_OFF_IRQ_MASK, 32'h0, OK);
        hit(4'h0, 1'b0, 1'b1);
        `CHK("irq", 1'b0, irq)
        xfer(1'b0, `SSS_OFF_IRQ_STAT, 32'h2, OK);
        chk_all();
        stop_test();
    end
endmodule : tb
`default_nettype wire
